/* File: caos_pkg.sv */
package caos_pkg;

    // Instruction group handled by the datapath; the top code is illegal
    typedef enum logic [2:0] {
        rotate_right_carry_op,
        literal_minus_acc_op,
        reg_minus_acc_op,
        xor_acc_reg_op,
        xor_acc_literal_op,
        nibble_swap_op,
        sleep_op
    } caos_op_t;

    // Register byte offsets (low 12 address bits)
    localparam logic [11:0] CAOS_OFF_CTRL   = 12'h000;
    localparam logic [11:0] CAOS_OFF_STATUS = 12'h004;
    localparam logic [11:0] CAOS_OFF_ACC    = 12'h008;
    localparam logic [11:0] CAOS_OFF_WDT    = 12'h00C;
    localparam logic [11:0] CAOS_FILE_BASE  = 12'h200;  // 128 words, one byte each
    localparam logic [19:0] CAOS_HI_ZERO    = 20'h00000; // Upper address bits of the map

    // Control register bits
    localparam int CAOS_CTRL_WDT_EN = 0;    // Watchdog runs
    localparam int CAOS_CTRL_WAKE   = 1;    // Write 1 leaves sleep

    // Status register bits
    localparam int CAOS_ST_C     = 0;
    localparam int CAOS_ST_DC    = 1;
    localparam int CAOS_ST_Z     = 2;
    localparam int CAOS_ST_PD_N  = 3;
    localparam int CAOS_ST_TO_N  = 4;
    localparam int CAOS_ST_SLEEP = 5;

    // Watchdog readback fields
    localparam int CAOS_WDT_CNT_LSB = 0;
    localparam int CAOS_WDT_PRE_LSB = 8;

    // Reset values
    localparam logic [7:0] CAOS_RST_ACC    = 8'h00;
    localparam logic       CAOS_RST_TO_N   = 1'h1;
    localparam logic       CAOS_RST_PD_N   = 1'h1;
    localparam logic       CAOS_RST_OSC    = 1'h1;
    localparam logic       CAOS_RST_WDT_EN = 1'h0;
    localparam logic       CAOS_RST_READY  = 1'h1;

    // Watchdog counts
    localparam logic [7:0] CAOS_WDT_PRE_MAX = 8'hFF;
    localparam logic [7:0] CAOS_WDT_CNT_MAX = 8'hFF;
    localparam logic [7:0] CAOS_WDT_CLEAR   = 8'h00;

    // AHB-Lite encodings
    localparam logic [1:0] CAOS_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] CAOS_HSIZE_WORD    = 3'h2;
    localparam logic       CAOS_HRESP_OKAY    = 1'h0;

endpackage : caos_pkg

/* File: caos_alu.sv */
`timescale 1ns/100ps
// Pure combinational result and flag generation
module caos_alu (
    input  wire caos_pkg::caos_op_t op,
    input  wire logic [7:0]         acc,
    input  wire logic [7:0]         fval,
    input  wire logic [7:0]         lit,
    input  wire logic               c_in,
    output logic [7:0]              result,
    output logic                    c_out,
    output logic                    dc_out,
    output logic                    z_out,
    output logic                    upd_c,
    output logic                    upd_dc,
    output logic                    upd_z
);

    // Subtraction as add of complement, so carry means no borrow
    always_comb begin
        logic [7:0] minuend;
        logic [8:0] sub_full;
        logic [4:0] sub_low;
        minuend  = (op == caos_pkg::literal_minus_acc_op) ? lit : fval;
        sub_full = {1'h0, minuend} + {1'h0, ~acc} + 9'h001;
        sub_low  = {1'h0, minuend[3:0]} + {1'h0, ~acc[3:0]} + 5'h01;
        result   = fval;
        c_out    = c_in;
        dc_out   = 1'h0;
        upd_c    = 1'h0;
        upd_dc   = 1'h0;
        upd_z    = 1'h0;
        unique case (op)
            caos_pkg::rotate_right_carry_op: begin
                result = {c_in, fval[7:1]};
                c_out  = fval[0];
                upd_c  = 1'h1;
            end
            caos_pkg::literal_minus_acc_op,
            caos_pkg::reg_minus_acc_op: begin
                result = sub_full[7:0];
                c_out  = sub_full[8];
                dc_out = sub_low[4];
                upd_c  = 1'h1;
                upd_dc = 1'h1;
                upd_z  = 1'h1;
            end
            caos_pkg::xor_acc_reg_op: begin
                result = acc ^ fval;
                upd_z  = 1'h1;
            end
            caos_pkg::xor_acc_literal_op: begin
                result = acc ^ lit;
                upd_z  = 1'h1;
            end
            caos_pkg::nibble_swap_op: begin
                result = {fval[3:0], fval[7:4]};
            end
            caos_pkg::sleep_op: begin
                result = fval;                      // No data result
            end
            default: begin
                result = fval;                      // Illegal code passes fval through with no flag update; the top still loads it into acc when exec_dest is 0
            end
        endcase
        z_out = (result == 8'h00);
    end

endmodule : caos_alu

/* File: caos_wdt.sv */
`timescale 1ns/100ps
// Watchdog: prescaler then counter, one timeout pulse on wrap
module caos_wdt #(
    parameter logic [7:0] PRE_LIMIT = caos_pkg::CAOS_WDT_PRE_MAX
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic en,
    input  wire logic clr,
    output logic [7:0] pre,
    output logic [7:0] cnt,
    output logic       tout
);

    typedef struct packed {
        logic [7:0] pre;    // Prescaler
        logic [7:0] cnt;    // Watchdog count
        logic       tout;   // Timeout pulse
    } caos_wdt_st_t;

    caos_wdt_st_t st_ff;
    caos_wdt_st_t nxt_st;

    // Clear beats counting so a sleep always restarts the full period
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.tout = 1'h0;
        if (clr) begin
            nxt_st.pre = caos_pkg::CAOS_WDT_CLEAR;
            nxt_st.cnt = caos_pkg::CAOS_WDT_CLEAR;
        end else if (en) begin
            if (st_ff.pre == PRE_LIMIT) begin
                nxt_st.pre = caos_pkg::CAOS_WDT_CLEAR;
                if (st_ff.cnt == caos_pkg::CAOS_WDT_CNT_MAX) begin
                    nxt_st.cnt  = caos_pkg::CAOS_WDT_CLEAR;
                    nxt_st.tout = 1'h1;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 8'h01;
                end
            end else begin
                nxt_st.pre = st_ff.pre + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pre  = st_ff.pre;
    assign cnt  = st_ff.cnt;
    assign tout = st_ff.tout;

endmodule : caos_wdt

/* File: caos_top.sv */
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
module caos_top #(
    parameter logic [7:0] WDT_PRE_LIMIT = caos_pkg::CAOS_WDT_PRE_MAX
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               exec_valid,
    input  wire caos_pkg::caos_op_t exec_op,
    input  wire logic [6:0]         exec_addr,
    input  wire logic               exec_dest,
    input  wire logic [7:0]         exec_lit,
    input  wire logic               wake_req,
    output logic [7:0]              acc_value,
    output logic                    sleep_state,
    output logic                    osc_run
);

    typedef struct packed {
        logic [127:0][7:0] file;        // Register file
        logic [7:0]        acc;         // Working register
        logic              c;           // Carry
        logic              dc;          // Digit carry
        logic              z;           // Zero
        logic              to_n;        // Timeout flag, low after timeout
        logic              pd_n;        // Powerdown flag, low after sleep
        logic              sleep;       // In sleep
        logic              osc_run;     // Oscillator enable
        logic              wdt_en;      // Watchdog enable
        logic              dp_wr;       // Write data phase pending
        logic [11:0]       dp_addr;     // Its address
        logic [31:0]       rdata;       // Read data
        logic              readyout;    // Bus ready
        logic              resp;        // Bus response
        logic [6:0]        chk_addr;    // Last operand address, checks only
        logic              chk_dest;    // Last destination bit, checks only
    } caos_top_st_t;

    caos_top_st_t st_ff;        // Registered state
    caos_top_st_t nxt_st;       // Next state

    logic       exec_take;      // Instruction accepted this cycle
    logic       wdt_clr;        // Sleep restarts watchdog
    logic [7:0] wdt_pre;        // Watchdog prescaler
    logic [7:0] wdt_cnt;        // Watchdog count
    logic       wdt_tout;       // Watchdog timeout pulse
    logic [7:0] fval;           // Addressed register value
    logic [7:0] alu_res;        // Datapath result
    logic       alu_c;
    logic       alu_dc;
    logic       alu_z;
    logic       upd_c;
    logic       upd_dc;
    logic       upd_z;
    logic       lit_op;         // Literal ops always target accumulator
    logic       addr_ok;        // Address phase taken
    logic       in_map;         // Address inside this block

    // Decoder gets no stall: instructions offered in sleep are dropped
    assign exec_take = exec_valid && !st_ff.sleep;
    assign wdt_clr   = exec_take && (exec_op == caos_pkg::sleep_op);
    assign fval      = st_ff.file[exec_addr];
    assign lit_op    = (exec_op == caos_pkg::literal_minus_acc_op)
                    || (exec_op == caos_pkg::xor_acc_literal_op);
    assign addr_ok   = hsel && hready && (htrans == caos_pkg::CAOS_HTRANS_NONSEQ);
    assign in_map    = (haddr[31:12] == caos_pkg::CAOS_HI_ZERO);

    // Datapath
    caos_alu u_alu (
        .op     (exec_op),
        .acc    (st_ff.acc),
        .fval   (fval),
        .lit    (exec_lit),
        .c_in   (st_ff.c),
        .result (alu_res),
        .c_out  (alu_c),
        .dc_out (alu_dc),
        .z_out  (alu_z),
        .upd_c  (upd_c),
        .upd_dc (upd_dc),
        .upd_z  (upd_z)
    );

    // Watchdog
    caos_wdt #(
        .PRE_LIMIT (WDT_PRE_LIMIT)
    ) u_wdt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .en      (st_ff.wdt_en),
        .clr     (wdt_clr),
        .pre     (wdt_pre),
        .cnt     (wdt_cnt),
        .tout    (wdt_tout)
    );

    // Read mux; unaligned or unmapped addresses read zero
    function automatic logic [31:0] caos_read(
        input caos_top_st_t s,
        input logic [11:0]  a,
        input logic [7:0]   pre,
        input logic [7:0]   cnt
    );
        logic [31:0] rd;
        rd = 32'h00000000;
        if (a[11:9] == caos_pkg::CAOS_FILE_BASE[11:9]) begin
            if (a[1:0] == 2'h0) begin
                rd[7:0] = s.file[a[8:2]];
            end
        end else begin
            case (a)
                caos_pkg::CAOS_OFF_CTRL: begin
                    rd[caos_pkg::CAOS_CTRL_WDT_EN] = s.wdt_en;
                end
                caos_pkg::CAOS_OFF_STATUS: begin
                    rd[caos_pkg::CAOS_ST_C]     = s.c;
                    rd[caos_pkg::CAOS_ST_DC]    = s.dc;
                    rd[caos_pkg::CAOS_ST_Z]     = s.z;
                    rd[caos_pkg::CAOS_ST_PD_N]  = s.pd_n;
                    rd[caos_pkg::CAOS_ST_TO_N]  = s.to_n;
                    rd[caos_pkg::CAOS_ST_SLEEP] = s.sleep;
                end
                caos_pkg::CAOS_OFF_ACC: begin
                    rd[7:0] = s.acc;
                end
                caos_pkg::CAOS_OFF_WDT: begin
                    rd[caos_pkg::CAOS_WDT_CNT_LSB +: 8] = cnt;
                    rd[caos_pkg::CAOS_WDT_PRE_LSB +: 8] = pre;
                end
                default: begin
                    rd = 32'h00000000;
                end
            endcase
        end
        return rd;
    endfunction : caos_read

    // Next state: bus write, then wake, then instruction, then timeout.
    // Later steps win, so hardware updates beat a software write.
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.readyout = caos_pkg::CAOS_RST_READY;
        nxt_st.resp     = caos_pkg::CAOS_HRESP_OKAY;
        nxt_st.chk_addr = exec_addr;
        nxt_st.chk_dest = exec_dest;
        // Data phase write
        if (st_ff.dp_wr) begin
            if (st_ff.dp_addr[11:9] == caos_pkg::CAOS_FILE_BASE[11:9]) begin
                if (st_ff.dp_addr[1:0] == 2'h0) begin
                    nxt_st.file[st_ff.dp_addr[8:2]] = hwdata[7:0];
                end
            end else begin
                case (st_ff.dp_addr)
                    caos_pkg::CAOS_OFF_CTRL: begin
                        nxt_st.wdt_en = hwdata[caos_pkg::CAOS_CTRL_WDT_EN];
                        if (hwdata[caos_pkg::CAOS_CTRL_WAKE]) begin
                            nxt_st.sleep   = 1'h0;
                            nxt_st.osc_run = 1'h1;
                        end
                    end
                    caos_pkg::CAOS_OFF_STATUS: begin
                        // Sleep flags are read only
                        nxt_st.c  = hwdata[caos_pkg::CAOS_ST_C];
                        nxt_st.dc = hwdata[caos_pkg::CAOS_ST_DC];
                        nxt_st.z  = hwdata[caos_pkg::CAOS_ST_Z];
                    end
                    caos_pkg::CAOS_OFF_ACC: begin
                        nxt_st.acc = hwdata[7:0];
                    end
                    default: begin
                        nxt_st.dp_wr = 1'h0;    // Ignored
                    end
                endcase
            end
        end
        // Address phase; zero wait states
        nxt_st.dp_wr   = addr_ok && in_map && hwrite && (hsize == caos_pkg::CAOS_HSIZE_WORD);
        nxt_st.dp_addr = haddr[11:0];
        if (addr_ok && !hwrite) begin
            nxt_st.rdata = in_map ? caos_read(st_ff, haddr[11:0], wdt_pre, wdt_cnt)
                                  : 32'h00000000;
        end
        // Wake pin
        if (wake_req) begin
            nxt_st.sleep   = 1'h0;
            nxt_st.osc_run = 1'h1;
        end
        // Instruction
        if (exec_take) begin
            if (exec_op == caos_pkg::sleep_op) begin
                nxt_st.to_n    = 1'h1;
                nxt_st.pd_n    = 1'h0;
                nxt_st.sleep   = 1'h1;
                nxt_st.osc_run = 1'h0;
            end else begin
                if (lit_op || !exec_dest) begin
                    nxt_st.acc = alu_res;
                end else if (exec_op != caos_pkg::caos_op_t'(3'h7)) begin
                    nxt_st.file[exec_addr] = alu_res;
                end
                if (upd_c) begin
                    nxt_st.c = alu_c;
                end
                if (upd_dc) begin
                    nxt_st.dc = alu_dc;
                end
                if (upd_z) begin
                    nxt_st.z = alu_z;
                end
            end
        end
        // Watchdog timeout marks the flag and ends sleep
        if (wdt_tout) begin
            nxt_st.to_n    = 1'h0;
            nxt_st.sleep   = 1'h0;
            nxt_st.osc_run = 1'h1;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff          <= '0;
            st_ff.acc      <= caos_pkg::CAOS_RST_ACC;
            st_ff.to_n     <= caos_pkg::CAOS_RST_TO_N;
            st_ff.pd_n     <= caos_pkg::CAOS_RST_PD_N;
            st_ff.osc_run  <= caos_pkg::CAOS_RST_OSC;
            st_ff.wdt_en   <= caos_pkg::CAOS_RST_WDT_EN;
            st_ff.readyout <= caos_pkg::CAOS_RST_READY;
            st_ff.resp     <= caos_pkg::CAOS_HRESP_OKAY;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hrdata      = st_ff.rdata;
    assign hreadyout   = st_ff.readyout;
    assign hresp       = st_ff.resp;
    assign acc_value   = st_ff.acc;
    assign sleep_state = st_ff.sleep;
    assign osc_run     = st_ff.osc_run;

    // Checks below: destination seen one cycle after an instruction
    logic [7:0] dst_val;
    logic       fval_lsb;
    logic [3:0] acc_lo;
    logic [3:0] lit_lo;
    logic [3:0] fval_lo;
    assign dst_val  = st_ff.chk_dest ? st_ff.file[st_ff.chk_addr] : st_ff.acc;
    assign fval_lsb = fval[0];
    assign acc_lo   = st_ff.acc[3:0];
    assign lit_lo   = exec_lit[3:0];
    assign fval_lo  = fval[3:0];

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_sleep_status: assert property (
        exec_take && exec_op == caos_pkg::sleep_op && !wdt_tout
        |=> st_ff.to_n && !st_ff.pd_n)
        else $error("sleep did not set timeout and clear powerdown flag");

    a_wdt_cleared: assert property (
        wdt_clr |=> (wdt_cnt == 8'h00) && (wdt_pre == 8'h00))
        else $error("sleep did not clear watchdog");

    a_sleep_osc_off: assert property (
        exec_take && exec_op == caos_pkg::sleep_op && !wdt_tout
        |=> !osc_run && sleep_state ##1 (!osc_run || $past(wake_req) || $past(wdt_tout)
            || $past(st_ff.dp_wr)))
        else $error("oscillator still running after sleep");

    a_rotate_value: assert property (
        exec_take && exec_op == caos_pkg::rotate_right_carry_op && !st_ff.dp_wr
        |=> dst_val[6:0] == 7'($past(fval) >> 1) && $stable(st_ff.z) && $stable(st_ff.dc))
        else $error("rotate result wrong or extra flag changed");

    a_rotate_carry: assert property (
        exec_take && exec_op == caos_pkg::rotate_right_carry_op && !st_ff.dp_wr
        |=> st_ff.c == $past(fval_lsb) && dst_val[7] == $past(st_ff.c))
        else $error("rotate carry path wrong");

    a_dest_to_acc: assert property (
        exec_take && !lit_op && exec_op != caos_pkg::sleep_op && !exec_dest
        && !st_ff.dp_wr |=> st_ff.file[$past(exec_addr)] == $past(fval))
        else $error("destination 0 wrote the register file");

    a_dest_to_file: assert property (
        exec_take && !lit_op && exec_op != caos_pkg::sleep_op && exec_dest
        && !st_ff.dp_wr |=> $stable(st_ff.acc))
        else $error("destination 1 wrote the accumulator");

    a_lit_sub_math: assert property (
        exec_take && exec_op == caos_pkg::literal_minus_acc_op
        |=> st_ff.acc == 8'($past(exec_lit) - $past(st_ff.acc)))
        else $error("literal minus accumulator wrong");

    a_sub_carries: assert property (
        exec_take && exec_op == caos_pkg::literal_minus_acc_op
        |=> st_ff.c == ($past(st_ff.acc) <= $past(exec_lit))
            && st_ff.dc == ($past(acc_lo) <= $past(lit_lo)))
        else $error("subtract carry or digit carry wrong");

    a_reg_sub_math: assert property (
        exec_take && exec_op == caos_pkg::reg_minus_acc_op && !st_ff.dp_wr
        |=> dst_val == 8'($past(fval) - $past(st_ff.acc))
            && st_ff.c == ($past(st_ff.acc) <= $past(fval))
            && st_ff.dc == ($past(acc_lo) <= $past(fval_lo)))
        else $error("register minus accumulator wrong");

    a_xor_reg_zero: assert property (
        exec_take && exec_op == caos_pkg::xor_acc_reg_op && !st_ff.dp_wr
        |=> dst_val == ($past(fval) ^ $past(st_ff.acc)) && st_ff.z == (dst_val == 8'h00)
            && $stable(st_ff.c))
        else $error("xor with register wrong");

    a_swap_flags: assert property (
        exec_take && exec_op == caos_pkg::nibble_swap_op && !st_ff.dp_wr
        |=> dst_val == {$past(fval_lo), 4'($past(fval) >> 4)}
            && $stable(st_ff.c) && $stable(st_ff.dc) && $stable(st_ff.z))
        else $error("nibble swap wrong or flags changed");

    a_xor_lit_zero: assert property (
        exec_take && exec_op == caos_pkg::xor_acc_literal_op && !st_ff.dp_wr
        |=> st_ff.acc == ($past(exec_lit) ^ $past(st_ff.acc))
            && st_ff.z == (st_ff.acc == 8'h00) && $stable(st_ff.dc))
        else $error("xor with literal wrong");

    a_zero_exact: assert property (
        exec_take && exec_op == caos_pkg::literal_minus_acc_op
        |=> st_ff.z == ($past(exec_lit) == $past(st_ff.acc)))
        else $error("zero flag wrong after subtract");

endmodule : caos_top

/* File: caos_dec_model.sv */
`timescale 1ns/100ps
// Decoder stand-in: one strobe per call, opcode parked on the illegal code between
module caos_dec_model (
    input  wire logic          hclk,
    output logic               exec_valid,
    output caos_pkg::caos_op_t exec_op,
    output logic [6:0]         exec_addr,
    output logic               exec_dest,
    output logic [7:0]         exec_lit
);
    // Idle values from time zero
    initial begin
        exec_valid = 1'h0;
        exec_op    = caos_pkg::caos_op_t'(3'h7);
        exec_addr  = 7'h00;
        exec_dest  = 1'h0;
        exec_lit   = 8'h00;
    end
    // Held for exactly one taken edge; literal inverted after so stale data never matches
    task automatic issue(input caos_pkg::caos_op_t op, input logic [6:0] a, input logic d,
                         input logic [7:0] k);
        @(posedge hclk);
        exec_valid <= 1'h1;
        exec_op    <= op;
        exec_addr  <= a;
        exec_dest  <= d;
        exec_lit   <= k;
        @(posedge hclk);
        exec_valid <= 1'h0;
        exec_op    <= caos_pkg::caos_op_t'(3'h7);
        exec_lit   <= ~k;
    endtask : issue
endmodule : caos_dec_model

/* File: cpu_alu_op_subset_tb_top.sv */
`timescale 1ns/100ps
module cpu_alu_op_subset_tb_top;
    logic               hclk = 1'h0;
    logic               hresetn = 1'h0;
    logic               hsel = 1'h0;
    logic [31:0]        haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0]         htrans = 2'h0;
    logic               hwrite = 1'h0, wake_req = 1'h0;
    logic               hready, hresp, sleep_state, osc_run, exec_valid, exec_dest;
    logic [7:0]         acc_value, exec_lit;
    logic [6:0]         exec_addr;
    caos_pkg::caos_op_t exec_op;
    int                 error_cnt = 0, n_checks = 0;
    // Operation table and packed {addr, dest, acc, operand} vectors
    caos_pkg::caos_op_t ops [9] = '{caos_pkg::literal_minus_acc_op,
        caos_pkg::literal_minus_acc_op, caos_pkg::xor_acc_literal_op,
        caos_pkg::rotate_right_carry_op, caos_pkg::rotate_right_carry_op,
        caos_pkg::reg_minus_acc_op, caos_pkg::reg_minus_acc_op,
        caos_pkg::xor_acc_reg_op, caos_pkg::nibble_swap_op};
    logic [23:0]        tv [9] = '{24'h000505, 24'h030605, 24'h005A5A, 24'hFF33A4,
        24'h0033A5, 24'h0B3130, 24'h0C1F20, 24'h0F3C3C, 24'h1000A5};
    // 200 MHz clock
    always #2.5 hclk = ~hclk;
    caos_dec_model DEC (.hclk(hclk), .exec_valid(exec_valid), .exec_op(exec_op),
        .exec_addr(exec_addr), .exec_dest(exec_dest), .exec_lit(exec_lit));
    // Short watchdog prescaler keeps the run brief
    caos_top #(.WDT_PRE_LIMIT(8'h03)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .exec_valid(exec_valid), .exec_op(exec_op), .exec_addr(exec_addr),
        .exec_dest(exec_dest), .exec_lit(exec_lit), .wake_req(wake_req),
        .acc_value(acc_value), .sleep_state(sleep_state), .osc_run(osc_run));
    // Verdict and end of run
    task automatic tally_and_finish;
        if (error_cnt == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Bounded wait for hready high at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'h1 && n < 50);
        if (hready !== 1'h1) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask : wait_rdy
    // Single word transfer; read data taken at the edge ending the data phase
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'h1;
        haddr  <= {20'h00000, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask : bus
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(nm, e, q);
    endtask : rc
    // Reference model: {z, dc, c, result}
    function automatic logic [10:0] ref_op(input caos_pkg::caos_op_t op,
                                           input logic [7:0] w, input logic [7:0] f);
        logic [7:0] r;
        logic [2:0] fl;
        fl = 3'h7;
        case (op)
            caos_pkg::rotate_right_carry_op: begin
                r = {fl[0], f[7:1]};
                fl[0] = f[0];
            end
            caos_pkg::literal_minus_acc_op, caos_pkg::reg_minus_acc_op: begin
                r = f - w;
                fl = {r == 8'h00, w[3:0] <= f[3:0], w <= f};
            end
            caos_pkg::nibble_swap_op: r = {f[3:0], f[7:4]};
            default: begin
                r = w ^ f;
                fl[2] = (r == 8'h00);
            end
        endcase
        return {fl, r};
    endfunction : ref_op
    // Every operation code except sleep, both destinations for the subtracts and rotate only, flags preset to all ones
    task automatic t_ops;
        logic [10:0] e;
        logic [11:0] fa;
        logic        td;
        for (int i = 0; i < 9; i++) begin
            fa = caos_pkg::CAOS_FILE_BASE + {3'h0, tv[i][23:17], 2'h0};
            bus(1'h1, fa, {24'h0, tv[i][7:0]});
            bus(1'h1, caos_pkg::CAOS_OFF_ACC, {24'h0, tv[i][15:8]});
            bus(1'h1, caos_pkg::CAOS_OFF_STATUS, 32'h7);
            DEC.issue(ops[i], tv[i][23:17], tv[i][16], tv[i][7:0]);
            e = ref_op(ops[i], tv[i][15:8], tv[i][7:0]);
            // Literal forms always land in the accumulator
            td = tv[i][16] & (ops[i] != caos_pkg::literal_minus_acc_op)
                & (ops[i] != caos_pkg::xor_acc_literal_op);
            rc("acc", caos_pkg::CAOS_OFF_ACC, {24'h0, td ? tv[i][15:8] : e[7:0]});
            rc("file", fa, {24'h0, td ? e[7:0] : tv[i][7:0]});
            rc("status", caos_pkg::CAOS_OFF_STATUS, {27'h0, 2'h3, e[10:8]});
        end
    endtask : t_ops
    // Watchdog timeout, then sleep with the watchdog stopped, dropped instruction, then wake
    task automatic t_sleep;
        bus(1'h1, caos_pkg::CAOS_OFF_CTRL, 32'h1);
        repeat (1100) @(posedge hclk);
        rc("to_n", caos_pkg::CAOS_OFF_STATUS, 32'h0F);
        bus(1'h1, caos_pkg::CAOS_OFF_CTRL, 32'h0);
        bus(1'h1, caos_pkg::CAOS_OFF_STATUS, 32'h0);
        DEC.issue(caos_pkg::sleep_op, 7'h00, 1'h0, 8'h00);
        #1;
        chk("osc_run", 32'h0, {31'h0, osc_run | ~sleep_state});
        rc("watchdog", caos_pkg::CAOS_OFF_WDT, 32'h0);
        rc("status", caos_pkg::CAOS_OFF_STATUS, 32'h30);
        DEC.issue(caos_pkg::xor_acc_literal_op, 7'h00, 1'h0, 8'hFF);
        rc("acc", caos_pkg::CAOS_OFF_ACC, 32'h5A);
        chk("acc_value", 32'h5A, {24'h0, acc_value});
        chk("hresp", 32'h0, {31'h0, hresp});
        @(posedge hclk);
        wake_req <= 1'h1;
        @(posedge hclk);
        wake_req <= 1'h0;
        #1;
        chk("wake", 32'h1, {31'h0, osc_run & ~sleep_state});
    endtask : t_sleep
    // Reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        t_ops();
        t_sleep();
        tally_and_finish();
    end
endmodule : cpu_alu_op_subset_tb_top
